/* File: hw/ltmc_defines.vh */
// Constants for the line test and maintenance control block.
// Assumes a 200 MHz system clock and four line ports.
`ifndef LTMC_DEFINES_VH
`define LTMC_DEFINES_VH

`define LTMC_LINES 4
`define LTMC_TALLY_W 16
`define LTMC_TALLY_MAX 16'hffff
`define LTMC_TALLY_ZERO 16'h0000

// Command codes on the command/indication channel
`define LTMC_CI_DR 4'h0
`define LTMC_CI_CLEAR 4'h1
`define LTMC_CI_PULSE 4'h5
`define LTMC_CI_THRU 4'h6
`define LTMC_CI_AR 4'h8
`define LTMC_CI_ALOOP 4'ha

// Channel select field and received channel tags
`define LTMC_ECS_STOP 2'h0
`define LTMC_ECS_B1 2'h1
`define LTMC_ECS_B2 2'h2
`define LTMC_ECS_ALL 2'h3
`define LTMC_CH_B1 2'h0
`define LTMC_CH_B2 2'h1
`define LTMC_CH_D 2'h2

// Timing
`define LTMC_CLK_PERIOD_PS 5000
`define LTMC_PULSE_SPACING_US 1000
`define LTMC_PULSE_CYC ((`LTMC_PULSE_SPACING_US * 1000000) / `LTMC_CLK_PERIOD_PS)

`endif

/* File: hw/ltmc_err_tally.v */
// One saturating bit error tally for a single line port.
// Assumes clear and hit are synchronous single-cycle strobes.
`timescale 1ns/10ps
`include "ltmc_defines.vh"
module ltmc_err_tally (
  clk,
  rst,
  clear,
  hit,
  tally
);
  input wire clk;
  input wire rst;
  input wire clear;
  input wire hit;
  output wire [`LTMC_TALLY_W-1:0] tally;

  reg [`LTMC_TALLY_W-1:0] tally_r;

  assign tally = tally_r;

  always @(posedge clk) begin
    if (rst) begin
      tally_r <= `LTMC_TALLY_ZERO;
    end else if (clear) begin
      // A hit in the clearing cycle is kept, not lost
      tally_r <= {{(`LTMC_TALLY_W-1){1'b0}}, hit}; // RULE3
    end else if (hit && tally_r != `LTMC_TALLY_MAX) begin
      tally_r <= tally_r + 16'h0001; // RULE6 RULE20
    end
  end
endmodule // ltmc_err_tally

/* File: hw/ltmc_line_test.v */
// Per-line test mode control and bit error tallies for four line ports.
// Assumes all inputs are synchronous to clk; commands arrive already decoded.
//
// Contract
// RULE1: Controller closes far loop and zeroes tested channel before measuring.
// RULE2: Controller selects the line port before touching its tally.
// RULE3: Reading the tally low byte clears the whole tally.
// RULE4: Nonzero channel select starts counting; controller waits a round trip first.
// RULE5: Channel select of zero stops counting.
// RULE6: Each received one in selected channels counts as an error.
// RULE7: Single-pulse mode sends one positive pulse per millisecond, nothing else.
// RULE8: Single-pulse mode entered by pin high or command 0101.
// RULE9: Pin modes hit all four lines; command modes only the addressed line.
// RULE10: Data-through jumps straight to transparent from any state.
// RULE11: Data-through sends scrambled signal without wake-up; pin or command 0110.
// RULE12: With data-through pin held, further commands still act.
// RULE13: Single-pulse and data-through pins work only with system interface active.
// RULE14: Clear state drives nothing onto the line.
// RULE15: Entering clear state wipes echo canceller and equalizer coefficients.
// RULE16: Clear state refuses and ignores activation.
// RULE17: Clear mode entered by low clear pin or command 0001.
// RULE18: Each port has a 16-bit tally over B1, B2 and D channels.
// RULE19: Test and loop commands travel as command/indication codes.
// RULE20: Tally saturates and does not count with channel select zero.
// RULE21: Withdrawn test mode returns the line to normal operation.
`timescale 1ns/10ps
`include "ltmc_defines.vh"
module ltmc_line_test #(
  parameter PULSE_CYC = `LTMC_PULSE_CYC
) (
  clk,
  rst,
  sys_if_active,
  single_pulse_test,
  data_through_test,
  chip_clear_n,
  ci_valid,
  ci_line,
  ci_code,
  line_port_select_wr,
  line_port_select_in,
  ecs_wr,
  ecs_in,
  tally_rd_lo,
  tally_rd_hi,
  act_req,
  act_done,
  deact_req,
  rx_valid,
  rx_bit,
  rx_chan,
  tally_rdata,
  line_port_select,
  tx_enable,
  tx_scrambled,
  tx_pulse,
  analog_loop_request,
  coef_clear,
  line_state
);
  input wire clk;
  input wire rst;
  input wire sys_if_active;
  input wire single_pulse_test;
  input wire data_through_test;
  input wire chip_clear_n;
  input wire ci_valid;
  input wire [1:0] ci_line;
  input wire [3:0] ci_code;
  input wire line_port_select_wr;
  input wire [1:0] line_port_select_in;
  input wire ecs_wr;
  input wire [1:0] ecs_in;
  input wire tally_rd_lo;
  input wire tally_rd_hi;
  input wire [3:0] act_req;
  input wire [3:0] act_done;
  input wire [3:0] deact_req;
  input wire [3:0] rx_valid;
  input wire [3:0] rx_bit;
  input wire [7:0] rx_chan;
  output wire [7:0] tally_rdata;
  output wire [1:0] line_port_select;
  output wire [3:0] tx_enable;
  output wire [3:0] tx_scrambled;
  output wire [3:0] tx_pulse;
  output wire [3:0] analog_loop_request;
  output wire [3:0] coef_clear;
  output wire [11:0] line_state;

  localparam [2:0] ST_DEACT = 3'h0;
  localparam [2:0] ST_ACTIV = 3'h1;
  localparam [2:0] ST_TRANSP = 3'h2;
  localparam [2:0] ST_CLEAR = 3'h3;
  localparam [2:0] ST_PULSE = 3'h4;

  reg [1:0] port_sel_r;
  reg [7:0] rdata_r;
  reg [17:0] ms_cnt_r;
  reg ms_tick_r;
  wire [63:0] tally_all;
  wire [15:0] tally_sel;

  assign line_port_select = port_sel_r;
  assign tally_rdata = rdata_r;

  // Pin modes are shared by all lines; test pins wait for the system interface
  wire hw_clear = ~chip_clear_n; // RULE17 RULE9
  wire hw_pulse = single_pulse_test & sys_if_active; // RULE13 RULE8
  wire hw_thru = data_through_test & sys_if_active; // RULE13 RULE11

  always @(posedge clk) begin
    if (rst) begin
      port_sel_r <= 2'h0;
    end else if (line_port_select_wr) begin
      port_sel_r <= line_port_select_in; // RULE2
    end
  end

  // One shared millisecond timer keeps pulse spacing exact on every line
  always @(posedge clk) begin
    if (rst) begin
      ms_cnt_r <= 18'h0_0000;
      ms_tick_r <= 1'b0;
    end else if (ms_cnt_r == PULSE_CYC[17:0] - 18'h0_0001) begin
      ms_cnt_r <= 18'h0_0000;
      ms_tick_r <= 1'b1; // RULE7
    end else begin
      ms_cnt_r <= ms_cnt_r + 18'h0_0001;
      ms_tick_r <= 1'b0;
    end
  end

  assign tally_sel = tally_all[port_sel_r*16 +: 16];

  always @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (tally_rd_lo) begin
      rdata_r <= tally_sel[7:0];
    end else if (tally_rd_hi) begin
      rdata_r <= tally_sel[15:8];
    end
  end

  genvar i;
  generate
    for (i = 0; i < `LTMC_LINES; i = i + 1) begin : g_line
      reg [3:0] cmd_r;
      reg [2:0] st_r;
      reg [2:0] st_nxt;
      reg thru_forced_r;
      reg [1:0] ecs_r;
      reg tx_en_r;
      reg tx_scr_r;
      reg tx_pls_r;
      reg loop_r;
      reg coef_clr_r;
      wire cmd_here = ci_valid && ci_line == i[1:0]; // RULE9 RULE19
      wire clear_m = hw_clear || cmd_r == `LTMC_CI_CLEAR; // RULE17
      wire pulse_m = hw_pulse || cmd_r == `LTMC_CI_PULSE; // RULE8
      wire thru_m = hw_thru || cmd_r == `LTMC_CI_THRU; // RULE11
      wire [1:0] ch = rx_chan[i*2 +: 2];
      wire ch_match = (ecs_r == `LTMC_ECS_B1 && ch == `LTMC_CH_B1) ||
                      (ecs_r == `LTMC_ECS_B2 && ch == `LTMC_CH_B2) ||
                      (ecs_r == `LTMC_ECS_ALL && (ch == `LTMC_CH_B1 ||
                       ch == `LTMC_CH_B2 || ch == `LTMC_CH_D)); // RULE18
      // Stopped field never matches, so the tally holds
      wire hit = rx_valid[i] && rx_bit[i] && ch_match; // RULE6 RULE5 RULE20
      wire clr = tally_rd_lo && port_sel_r == i[1:0]; // RULE3

      // Command codes are taken even while a pin mode holds the line
      always @(posedge clk) begin
        if (rst) begin
          cmd_r <= `LTMC_CI_DR;
          loop_r <= 1'b0;
          ecs_r <= `LTMC_ECS_STOP;
        end else begin
          if (cmd_here) begin
            cmd_r <= ci_code; // RULE12 RULE21
            if (ci_code == `LTMC_CI_ALOOP) begin
              loop_r <= 1'b1; // RULE12
            end else if (ci_code == `LTMC_CI_AR || ci_code == `LTMC_CI_DR) begin
              loop_r <= 1'b0;
            end
          end
          if (ecs_wr && port_sel_r == i[1:0]) begin
            ecs_r <= ecs_in; // RULE4 RULE5
          end
        end
      end

      always @* begin
        st_nxt = st_r;
        if (clear_m) begin
          st_nxt = ST_CLEAR; // RULE16 RULE17
        end else if (pulse_m) begin
          st_nxt = ST_PULSE; // RULE8
        end else if (thru_m) begin
          st_nxt = ST_TRANSP; // RULE10
        end else if (st_r == ST_CLEAR || st_r == ST_PULSE || thru_forced_r) begin
          st_nxt = ST_DEACT; // RULE21
        end else begin
          case (st_r)
            ST_DEACT: begin
              if (act_req[i]) begin
                st_nxt = ST_ACTIV;
              end
            end
            ST_ACTIV: begin
              if (deact_req[i]) begin
                st_nxt = ST_DEACT;
              end else if (act_done[i]) begin
                st_nxt = ST_TRANSP;
              end
            end
            ST_TRANSP: begin
              if (deact_req[i]) begin
                st_nxt = ST_DEACT;
              end
            end
            default: begin
              st_nxt = ST_DEACT;
            end
          endcase
        end
      end

      always @(posedge clk) begin
        if (rst) begin
          st_r <= ST_DEACT;
          thru_forced_r <= 1'b0;
          tx_en_r <= 1'b0;
          tx_scr_r <= 1'b0;
          tx_pls_r <= 1'b0;
          coef_clr_r <= 1'b0;
        end else begin
          st_r <= st_nxt;
          thru_forced_r <= ~clear_m & ~pulse_m & thru_m;
          // Deactivated and clear states keep the driver quiet
          tx_en_r <= st_nxt == ST_ACTIV || st_nxt == ST_TRANSP ||
                     st_nxt == ST_PULSE; // RULE14
          tx_scr_r <= st_nxt == ST_TRANSP; // RULE11
          tx_pls_r <= st_nxt == ST_PULSE && ms_tick_r; // RULE7
          coef_clr_r <= st_nxt == ST_CLEAR && st_r != ST_CLEAR; // RULE15
        end
      end

      ltmc_err_tally u_tally (
        .clk(clk),
        .rst(rst),
        .clear(clr),
        .hit(hit),
        .tally(tally_all[i*16 +: 16])
      );

      assign tx_enable[i] = tx_en_r;
      assign tx_scrambled[i] = tx_scr_r;
      assign tx_pulse[i] = tx_pls_r;
      assign analog_loop_request[i] = loop_r;
      assign coef_clear[i] = coef_clr_r;
      assign line_state[i*3 +: 3] = st_r;
    end
  endgenerate
endmodule // ltmc_line_test

/* File: verif/ltmc_line_test_props.sv */
// Checker for the line test block, watching its ports only.
// Assumes a bind from the bench top and a synchronous active-high reset.
`timescale 1ns/10ps
module ltmc_line_test_props #(
  parameter PULSE_CYC = 20
) (
  input wire clk,
  input wire rst,
  input wire sys_if_active,
  input wire single_pulse_test,
  input wire chip_clear_n,
  input wire ci_valid,
  input wire [1:0] ci_line,
  input wire [3:0] ci_code,
  input wire line_port_select_wr,
  input wire tally_rd_lo,
  input wire [3:0] act_req,
  input wire [3:0] rx_valid,
  input wire [7:0] tally_rdata,
  input wire [3:0] tx_enable,
  input wire [3:0] tx_scrambled,
  input wire [3:0] tx_pulse,
  input wire [3:0] coef_clear,
  input wire [11:0] line_state
);
  int gap_r;
  logic seen_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Gap since last pulse; the first pulse has no reference
  always @(posedge clk) begin
    gap_r <= (rst || tx_pulse[0]) ? 0 : gap_r + 1;
    seen_r <= rst ? 1'b0 : (seen_r || tx_pulse[0]);
  end
  property p_cmd_clr; ci_valid && ci_line == 2'h2 && ci_code == 4'h1 |-> ##2 line_state[8:6] == 3'h3; endproperty
  a_cmd_clr: assert property (p_cmd_clr) else $error("clear command missed");
  property p_cmd_thru; ci_valid && ci_line == 2'h2 && ci_code == 4'h6 ##1 chip_clear_n && !(single_pulse_test && sys_if_active) |=> tx_scrambled[2] && line_state[8:6] == 3'h2; endproperty
  a_cmd_thru: assert property (p_cmd_thru) else $error("data through missed");
  property p_pin_clr; !chip_clear_n |=> line_state == 12'h6db; endproperty
  a_pin_clr: assert property (p_pin_clr) else $error("clear pin missed");
  property p_pin_sp; single_pulse_test && sys_if_active && chip_clear_n |=> line_state == 12'h924; endproperty
  a_pin_sp: assert property (p_pin_sp) else $error("pulse pin missed");
  property p_quiet; line_state[2:0] == 3'h3 |-> !tx_enable[0] && !tx_pulse[0] && !tx_scrambled[0]; endproperty
  a_quiet: assert property (p_quiet) else $error("line driven in clear");
  property p_coef; line_state[2:0] == 3'h3 && $past(line_state[2:0]) != 3'h3 |-> coef_clear[0]; endproperty
  a_coef: assert property (p_coef) else $error("coefficients kept");
  property p_no_act; line_state[2:0] == 3'h3 && act_req[0] |=> line_state[2:0] != 3'h1; endproperty
  a_no_act: assert property (p_no_act) else $error("activated from clear");
  property p_pulse; tx_pulse[0] && seen_r |-> (gap_r + 1) % PULSE_CYC == 0; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse spacing wrong");
  property p_rd_clr; (tally_rd_lo && rx_valid == 4'h0 && !line_port_select_wr) [*3] |=> tally_rdata == 8'h00; endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("tally not cleared");
  c_pulse: cover property (tx_pulse[0]);
  c_coef: cover property (coef_clear[0]);
  c_thru: cover property (tx_scrambled[2]);
endmodule // ltmc_line_test_props

/* File: verif/ltmc_ctrl_model.sv */
// Exchange-side controller model: commands, port select, channel select, reads.
// Assumes tasks are called from the bench; all changes at the falling edge.
`timescale 1ns/10ps
module ltmc_ctrl_model (
  input wire clk,
  output reg ci_valid = 1'b0,
  output reg [1:0] ci_line = 2'h0,
  output reg [3:0] ci_code = 4'h0,
  output reg line_port_select_wr = 1'b0,
  output reg [1:0] line_port_select_in = 2'h0,
  output reg ecs_wr = 1'b0,
  output reg [1:0] ecs_in = 2'h0,
  output reg tally_rd_lo = 1'b0,
  output reg tally_rd_hi = 1'b0
);
  // Released data lines other than ci_line show the inverse so stale values cannot pass
  task cmd(input [1:0] ln, input [3:0] code);
    @(negedge clk);
    ci_line = ln;
    ci_code = code;
    ci_valid = 1'b1;
    @(negedge clk);
    ci_valid = 1'b0;
    ci_code = ~code;
  endtask
  task sel(input [1:0] pn);
    @(negedge clk);
    line_port_select_in = pn;
    line_port_select_wr = 1'b1;
    @(negedge clk);
    line_port_select_wr = 1'b0;
    line_port_select_in = ~pn;
  endtask
  task ecs(input [1:0] v);
    if (v != 2'h0)
      repeat (4) @(negedge clk);
    @(negedge clk);
    ecs_in = v;
    ecs_wr = 1'b1;
    @(negedge clk);
    ecs_wr = 1'b0;
    ecs_in = ~v;
  endtask
  task rd(input lo, input int n);
    @(negedge clk);
    tally_rd_lo = lo;
    tally_rd_hi = !lo;
    repeat (n) @(negedge clk);
    tally_rd_lo = 1'b0;
    tally_rd_hi = 1'b0;
    repeat (2) @(negedge clk);
  endtask
endmodule // ltmc_ctrl_model

/* File: verif/ltmc_line_test_tb.sv */
// Bench for the line test block with a controller model on the command side.
// Assumes a 200 MHz clock; pulse spacing shortened to PC cycles.
`timescale 1ns/10ps
module ltmc_line_test_tb;
  localparam int PC = 20;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg sys_if_active = 1'b0;
  reg single_pulse_test = 1'b0;
  reg data_through_test = 1'b0;
  reg chip_clear_n = 1'b1;
  reg [3:0] act_req = 4'h0;
  reg [3:0] act_done = 4'h0;
  reg [3:0] deact_req = 4'h0;
  reg [3:0] rx_valid = 4'h0;
  reg [3:0] rx_bit = 4'h0;
  reg [7:0] rx_chan = 8'h00;
  wire ci_valid, line_port_select_wr, ecs_wr, tally_rd_lo, tally_rd_hi;
  wire [1:0] ci_line, line_port_select_in, ecs_in, line_port_select;
  wire [3:0] ci_code, tx_enable, tx_scrambled, tx_pulse, analog_loop_request, coef_clear;
  wire [7:0] tally_rdata;
  wire [11:0] line_state;
  int error_cnt = 0;
  int comparisons = 0;
  int exp_cnt;
  int n;
  reg [1:0] p;
  reg [1:0] v;
  reg [3:0] codes [6] = '{4'h6, 4'h1, 4'h6, 4'h5, 4'h6, 4'h0};
  ltmc_line_test #(.PULSE_CYC(PC)) uut (.clk, .rst, .sys_if_active, .single_pulse_test,
    .data_through_test, .chip_clear_n, .ci_valid, .ci_line, .ci_code, .line_port_select_wr,
    .line_port_select_in, .ecs_wr, .ecs_in, .tally_rd_lo, .tally_rd_hi, .act_req, .act_done,
    .deact_req, .rx_valid, .rx_bit, .rx_chan, .tally_rdata, .line_port_select, .tx_enable,
    .tx_scrambled, .tx_pulse, .analog_loop_request, .coef_clear, .line_state);
  ltmc_ctrl_model u_ctrl (.clk, .ci_valid, .ci_line, .ci_code, .line_port_select_wr,
    .line_port_select_in, .ecs_wr, .ecs_in, .tally_rd_lo, .tally_rd_hi);
  always #2.5 clk = ~clk;
  task chk(input [15:0] got, input [15:0] want);
    comparisons++;
    if (got !== want) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task finish_test;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic bit hit(input [1:0] e, input [1:0] c);
    hit = (e == 2'h3) ? (c != 2'h3) : (c == e - 2'h1);
  endfunction
  function automatic [15:0] st(input [3:0] code);
    st = (code == 4'h1) ? 16'h0003 : (code == 4'h5) ? 16'h0004 : (code == 4'h6) ? 16'h0002 : 0;
  endfunction
  // Random traffic on all lines; only port p is expected to count
  task drive_rx(input int cyc, input bit cnt);
    repeat (cyc) begin
      rx_valid = $urandom;
      rx_bit = $urandom;
      rx_chan = $urandom;
      if (cnt && rx_valid[p] && rx_bit[p] && hit(v, rx_chan[2 * p +: 2]))
        exp_cnt++;
      @(negedge clk);
    end
    rx_valid = 4'h0;
  endtask
  initial begin
    #450000;
    error_cnt++;
    finish_test;
  end
  initial begin
    void'($urandom(60));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    chk(line_state, 16'h0000);
    foreach (codes[i]) begin
      u_ctrl.cmd(2'h2, codes[i]);
      repeat (2) @(negedge clk);
      chk(line_state, st(codes[i]) << 6);
      chk(tx_scrambled, (codes[i] == 4'h6) ? 16'h0004 : 16'h0000);
    end
    data_through_test = 1'b1;
    repeat (3) @(negedge clk);
    chk(line_state, 16'h0000);
    sys_if_active = 1'b1;
    u_ctrl.cmd(2'h3, 4'ha);
    repeat (3) @(negedge clk);
    chk(line_state, 16'h0492);
    chk(analog_loop_request, 16'h0008);
    data_through_test = 1'b0;
    repeat (2) @(negedge clk);
    chk(line_state, 16'h0000);
    single_pulse_test = 1'b1;
    n = 0;
    repeat (3 * PC) begin
      @(negedge clk);
      n += tx_pulse[1];
    end
    chk(line_state, 16'h0924);
    chk(n, 3);
    single_pulse_test = 1'b0;
    chip_clear_n = 1'b0;
    act_req = 4'hf;
    repeat (3) @(negedge clk);
    chk(line_state, 16'h06db);
    chk(tx_enable, 16'h0000);
    chip_clear_n = 1'b1;
    act_req = 4'h0;
    @(negedge clk);
    act_req = 4'h1;
    @(negedge clk);
    act_req = 4'h0;
    chk(line_state, 16'h0001);
    chk(tx_enable, 16'h0001);
    u_ctrl.cmd(2'h0, 4'h6);
    repeat (2) @(negedge clk);
    chk(line_state, 16'h0002);
    u_ctrl.cmd(2'h0, 4'h0);
    repeat (2) @(negedge clk);
    chk(line_state, 16'h0000);
    act_req = 4'h1;
    @(negedge clk);
    act_req = 4'h0;
    act_done = 4'h1;
    @(negedge clk);
    act_done = 4'h0;
    chk(line_state, 16'h0002);
    deact_req = 4'h1;
    @(negedge clk);
    deact_req = 4'h0;
    chk(line_state, 16'h0000);
    u_ctrl.cmd(2'h3, 4'h8);
    repeat (2) @(negedge clk);
    chk(analog_loop_request, 16'h0000);
    p = $urandom;
    v = $urandom_range(3, 1);
    rx_bit = 4'h0;
    u_ctrl.sel(p);
    chk(line_port_select, p);
    u_ctrl.rd(1'b1, 1);
    u_ctrl.ecs(v);
    exp_cnt = 0;
    drive_rx(200, 1'b1);
    u_ctrl.ecs(2'h0);
    drive_rx(50, 1'b0);
    u_ctrl.rd(1'b0, 1);
    chk(tally_rdata, exp_cnt >> 8);
    u_ctrl.rd(1'b1, 1);
    chk(tally_rdata, exp_cnt & 8'hff);
    u_ctrl.rd(1'b1, 3);
    chk(tally_rdata, 16'h0000);
    u_ctrl.ecs(2'h3);
    rx_valid = 4'hf;
    rx_bit = 4'hf;
    rx_chan = 8'h00;
    repeat (65540) @(negedge clk);
    rx_valid = 4'h0;
    u_ctrl.ecs(2'h0);
    u_ctrl.rd(1'b0, 1);
    chk(tally_rdata, 16'h00ff);
    finish_test;
  end
endmodule // ltmc_line_test_tb
bind ltmc_line_test ltmc_line_test_props #(.PULSE_CYC(PULSE_CYC)) u_props (.clk, .rst,
  .sys_if_active, .single_pulse_test, .chip_clear_n, .ci_valid, .ci_line, .ci_code,
  .line_port_select_wr, .tally_rd_lo, .act_req, .rx_valid, .tally_rdata, .tx_enable,
  .tx_scrambled, .tx_pulse, .coef_clear, .line_state);
